// ===== nitfc_top.sv
// Per-channel NAND interface timing registers and phase sequencers
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "nitfc_cfg.svh"

module nitfc_top #(
    parameter int NCH = 8
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic [11:0]          addr_in,
    input  wire logic [31:0]          wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [31:0]          rdata_out,
    input  wire logic [NCH-1:0]       ch_start_in,
    input  wire nitfc_pkg::nitfc_op_t ch_op_in [NCH],
    input  wire logic [NCH-1:0][7:0]  ch_len_in,
    input  wire logic [NCH-1:0]       ch_abort_in,
    input  wire logic [NCH-1:0]       ch_rb_in,
    output logic      [NCH-1:0]       ch_busy_out,
    output logic      [NCH-1:0]       ch_re_n_out,
    output logic      [NCH-1:0]       ch_re_c_out,
    output logic      [NCH-1:0]       ch_re_c_oe_out,
    output logic      [NCH-1:0]       ch_dqs_out,
    output logic      [NCH-1:0]       ch_dqs_oe_out,
    output logic      [NCH-1:0]       ch_dqs_c_out,
    output logic      [NCH-1:0]       ch_dqs_c_oe_out,
    output logic      [NCH-1:0]       ch_iface_clk_out,
    output logic      [NCH-1:0]       ch_capture_out,
    output logic      [NCH-1:0]       ch_data_req_out,
    output logic      [3:0]           odt_sel_out
);
    import nitfc_pkg::*;

    nitfc_state_t              st_ff;
    nitfc_state_t              nxt_st;
    nitfc_chan_t [NCH-1:0]     nxt_ch;
    nitfc_mode_t               mode;

    assign mode = nitfc_mode_t'(st_ff.ctl[`NITFC_F_MODE]);

    function automatic logic [2:0] nitfc_warm(input logic [3:0] code);
        case (code)
            `NITFC_WARM_1: nitfc_warm = 3'h1;
            `NITFC_WARM_2: nitfc_warm = 3'h2;
            `NITFC_WARM_4: nitfc_warm = 3'h4;
            default:       nitfc_warm = 3'h0;
        endcase
    endfunction : nitfc_warm

    // Register file, read port and termination select
    always_comb begin
        logic [31:0] rval;
        logic [3:0]  odt_req;
        logic [11:0] off;
        off     = 12'h000;
        odt_req = 4'h0;
        rval   = 32'h0000_0000;
        nxt_st = st_ff;
        for (int c = 0; c < NCH; c++) begin
            off = `NITFC_CH_STRIDE * 12'(c);
            for (int k = 0; k < 4; k++) begin
                logic [11:0] base;
                logic [31:0] mask;
                base = 12'h000;
                mask = 32'h0000_0000;
                case (k)
                    0:       begin base = `NITFC_ADDR_PW; mask = `NITFC_PW_MASK; end
                    1:       begin base = `NITFC_ADDR_LB; mask = `NITFC_LB_MASK; end
                    2:       begin base = `NITFC_ADDR_TG; mask = `NITFC_TG_MASK; end
                    default: begin base = `NITFC_ADDR_SA; mask = `NITFC_SA_MASK; end
                endcase
                if (addr_in == base + off) begin
                    rval = st_ff.tim[c][k];
                    if (wr_in) begin
                        nxt_st.tim[c][k] = wdata_in & mask;
                    end
                end
            end
        end
        if (addr_in == `NITFC_ADDR_ATTR) begin
            rval = st_ff.attr;
            if (wr_in) begin
                nxt_st.attr = wdata_in & `NITFC_ATTR_MASK;
            end
        end
        if (addr_in == `NITFC_ADDR_CTL) begin
            rval = st_ff.ctl;
            if (wr_in) begin
                nxt_st.ctl = wdata_in & `NITFC_CTL_MASK;
            end
        end
        if (addr_in == `NITFC_ADDR_STS) begin
            rval = {12'h000, st_ff.odt, ch_rb_in, ch_busy_out};
        end
        nxt_st.rdata = rd_in ? rval : 32'h0000_0000;
        // Configure-command value wins over the field without touching it
        odt_req = st_ff.ctl[`NITFC_F_OVR] ? st_ff.ctl[`NITFC_F_OVR_ODT]
                                          : st_ff.attr[`NITFC_F_ODT];
        // Reserved codes fall back to no termination rather than a guess
        nxt_st.odt = (odt_req > `NITFC_ODT_MAX) ? `NITFC_ODT_OFF : odt_req;
        nxt_st.ch  = nxt_ch;
    end

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            nitfc_chan_t c;
            logic        rd_act;
            logic        wr_act;

            assign c      = st_ff.ch[i];
            assign rd_act = !c.wr && (c.phase inside {NITFC_PH_PRE, NITFC_PH_WARM,
                                                      NITFC_PH_DATA, NITFC_PH_POST});
            assign wr_act = c.wr && (c.phase inside {NITFC_PH_PRE, NITFC_PH_WARM,
                                                     NITFC_PH_DATA, NITFC_PH_POST});

            always_comb begin
                nitfc_chan_t n;
                logic [31:0] t0;
                logic [31:0] t2;
                logic [31:0] t3;
                logic        nvddr;
                logic        iface_en;
                logic        tick;
                logic [12:0] beat_len;
                logic [12:0] pre_len;
                logic        last;
                n        = c;
                t0       = st_ff.tim[i][0];
                t2       = st_ff.tim[i][2];
                t3       = st_ff.tim[i][3];
                nvddr    = (mode == NITFC_MODE_NVDDR);
                n.cap    = 1'b0;
                n.dreq   = 1'b0;
                iface_en = 1'b0;
                // Free-running divider: half period of N+1 cycles
                if (c.div >= t0[`NITFC_F_RES]) begin
                    n.div    = 5'h00;
                    n.iclk   = ~c.iclk;
                    iface_en = ~c.iclk;
                end else begin
                    n.div = c.div + 5'h01;
                end
                // Amble and data phases step on the interface clock in NV-DDR
                tick = (nvddr && (c.phase inside {NITFC_PH_PRE, NITFC_PH_WARM, NITFC_PH_DATA,
                        NITFC_PH_POST, NITFC_PH_HOLD})) ? iface_en : 1'b1;
                beat_len = nvddr ? 13'h0000 : c.wr ? 13'(t0[`NITFC_F_WP])
                                                   : 13'(t0[`NITFC_F_RES]);
                pre_len  = (mode == NITFC_MODE_DDR2) ? 13'(t2[`NITFC_F_B2R])
                                                     : 13'(t3[`NITFC_F_PRE]);
                last     = (c.cnt == 13'h0000);
                case (c.phase)
                    NITFC_PH_IDLE: begin
                        if (ch_start_in[i]) begin
                            n.strobe = 1'b0;
                            n.beats  = ch_len_in[i];
                            case (ch_op_in[i])
                                NITFC_OP_READ: begin
                                    n.phase = NITFC_PH_GAP;
                                    n.wr    = 1'b0;
                                    n.cnt   = 13'(t2[`NITFC_F_B2R]);
                                    n.warm  = nitfc_warm(st_ff.attr[`NITFC_F_WARM_RD]);
                                end
                                NITFC_OP_WRITE: begin
                                    n.phase = NITFC_PH_GAP;
                                    n.wr    = 1'b1;
                                    n.cnt   = 13'(t2[`NITFC_F_C2W]);
                                    n.warm  = nitfc_warm(st_ff.attr[`NITFC_F_WARM_WR]);
                                end
                                NITFC_OP_TURN: begin
                                    n.phase = NITFC_PH_TAIL;
                                    n.cnt   = 13'(t2[`NITFC_F_W2R]);
                                end
                                default: begin
                                    n.phase = NITFC_PH_IDLE;
                                end
                            endcase
                        end
                    end
                    NITFC_PH_GAP: begin
                        if (!c.wr && !ch_rb_in[i]) begin
                            n.cnt = 13'(t2[`NITFC_F_B2R]);
                        end else if (last) begin
                            n.phase = NITFC_PH_PRE;
                            n.cnt   = pre_len;
                        end else begin
                            n.cnt = c.cnt - 13'h0001;
                        end
                    end
                    NITFC_PH_PRE: begin
                        if (tick) begin
                            if (!last) begin
                                n.cnt = c.cnt - 13'h0001;
                            end else if (c.warm != 3'h0) begin
                                n.phase = NITFC_PH_WARM;
                                n.cnt   = beat_len;
                            end else if (c.beats != 8'h00) begin
                                n.phase = NITFC_PH_DATA;
                                n.cnt   = beat_len;
                            end else begin
                                n.phase = NITFC_PH_POST;
                                n.cnt   = 13'(t3[`NITFC_F_PST]);
                            end
                        end
                    end
                    NITFC_PH_WARM: begin
                        if (tick) begin
                            if (!last) begin
                                n.cnt = c.cnt - 13'h0001;
                            end else begin
                                // Dummy beat: strobe moves, nothing is captured
                                n.strobe = ~c.strobe;
                                n.warm   = c.warm - 3'h1;
                                n.cnt    = beat_len;
                                if (c.warm == 3'h1) begin
                                    n.phase = (c.beats != 8'h00) ? NITFC_PH_DATA
                                                                 : NITFC_PH_POST;
                                    if (c.beats == 8'h00) begin
                                        n.cnt = 13'(t3[`NITFC_F_PST]);
                                    end
                                end
                            end
                        end
                    end
                    NITFC_PH_DATA: begin
                        if (tick) begin
                            if (!last) begin
                                n.cnt = c.cnt - 13'h0001;
                            end else begin
                                n.strobe = ~c.strobe;
                                n.cap    = !c.wr;
                                n.dreq   = c.wr;
                                n.beats  = c.beats - 8'h01;
                                n.cnt    = beat_len;
                                if (c.beats == 8'h01) begin
                                    n.phase = NITFC_PH_POST;
                                    n.cnt   = 13'(t3[`NITFC_F_PST]);
                                end
                            end
                        end
                    end
                    NITFC_PH_POST: begin
                        if (tick) begin
                            if (!last) begin
                                n.cnt = c.cnt - 13'h0001;
                            end else begin
                                n.phase = NITFC_PH_HOLD;
                                n.cnt   = 13'(t3[`NITFC_F_PSTH]);
                            end
                        end
                    end
                    NITFC_PH_HOLD: begin
                        if (tick) begin
                            if (!last) begin
                                n.cnt = c.cnt - 13'h0001;
                            end else if (!c.wr) begin
                                n.phase = NITFC_PH_TAIL;
                                n.cnt   = 13'(t2[`NITFC_F_R2W]);
                            end else begin
                                n.phase = NITFC_PH_IDLE;
                            end
                        end
                    end
                    NITFC_PH_TAIL: begin
                        if (last) begin
                            n.phase = NITFC_PH_IDLE;
                        end else begin
                            n.cnt = c.cnt - 13'h0001;
                        end
                    end
                    default: begin
                        n.phase = NITFC_PH_IDLE;
                    end
                endcase
                // Abort beats any phase; strobes go quiet for the whole gap while the interface clock runs on
                if (ch_abort_in[i]) begin
                    n.phase  = NITFC_PH_TAIL;
                    n.cnt    = 13'(t2[`NITFC_F_C2W]);
                    n.strobe = 1'b0;
                    n.warm   = 3'h0;
                    n.beats  = 8'h00;
                    n.cap    = 1'b0;
                    n.dreq   = 1'b0;
                end
                nxt_ch[i] = n;
            end

            assign ch_busy_out[i]      = (c.phase != NITFC_PH_IDLE);
            assign ch_re_n_out[i]      = !rd_act || c.strobe;
            assign ch_re_c_out[i]      = !(!rd_act || c.strobe);
            assign ch_re_c_oe_out[i]   = rd_act && st_ff.attr[`NITFC_F_REC];
            assign ch_dqs_out[i]       = wr_act && c.strobe;
            assign ch_dqs_oe_out[i]    = wr_act;
            assign ch_dqs_c_out[i]     = !(wr_act && c.strobe);
            assign ch_dqs_c_oe_out[i]  = wr_act && st_ff.attr[`NITFC_F_DQSC];
            assign ch_iface_clk_out[i] = c.iclk;
            assign ch_capture_out[i]   = c.cap;
            assign ch_data_req_out[i]  = c.dreq;
        end
    endgenerate

    assign rdata_out   = st_ff.rdata;
    assign odt_sel_out = st_ff.odt;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_ff      <= '0;
            st_ff.attr <= `NITFC_ATTR_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : nitfc_top

// ===== nitfc_cfg.svh
// Register map, field positions and reset values of the NAND interface timing block
`ifndef NITFC_CFG_SVH
`define NITFC_CFG_SVH

`define NITFC_ADDR_ATTR   12'h10c
`define NITFC_ADDR_PW     12'h110
`define NITFC_ADDR_LB     12'h114
`define NITFC_ADDR_TG     12'h190
`define NITFC_ADDR_SA     12'h194
`define NITFC_CH_STRIDE   12'h008
`define NITFC_ADDR_CTL    12'h1e0
`define NITFC_ADDR_STS    12'h1e4

`define NITFC_ATTR_MASK   32'h0000_ffff
`define NITFC_ATTR_RST    32'h0000_8000
`define NITFC_PW_MASK     32'h0f1f_0f1f
`define NITFC_LB_MASK     32'h003f_7f7f
`define NITFC_TG_MASK     32'h7f7f_7f7f
`define NITFC_SA_MASK     32'hff1f_001f
`define NITFC_CTL_MASK    32'h0000_f107

`define NITFC_F_DQSC      13
`define NITFC_F_REC       12
`define NITFC_F_ODT       11:8
`define NITFC_F_WARM_RD   7:4
`define NITFC_F_WARM_WR   3:0
`define NITFC_F_WP        20:16
`define NITFC_F_RES       4:0
`define NITFC_F_W2R       30:24
`define NITFC_F_R2W       22:16
`define NITFC_F_B2R       14:8
`define NITFC_F_C2W       6:0
`define NITFC_F_PRE       31:28
`define NITFC_F_PST       27:24
`define NITFC_F_PSTH      20:16
`define NITFC_F_MODE      2:0
`define NITFC_F_OVR       8
`define NITFC_F_OVR_ODT   15:12

`define NITFC_ODT_MAX     4'h5
`define NITFC_ODT_OFF     4'h0
`define NITFC_WARM_1      4'h1
`define NITFC_WARM_2      4'h2
`define NITFC_WARM_4      4'h3

`endif

// ===== nitfc_pkg.sv
// Types of the NAND interface timing block
package nitfc_pkg;

    typedef enum logic [2:0] {
        NITFC_PH_IDLE,
        NITFC_PH_GAP,
        NITFC_PH_PRE,
        NITFC_PH_WARM,
        NITFC_PH_DATA,
        NITFC_PH_POST,
        NITFC_PH_HOLD,
        NITFC_PH_TAIL
    } nitfc_phase_t;

    typedef enum logic [1:0] {
        NITFC_OP_READ,
        NITFC_OP_WRITE,
        NITFC_OP_TURN,
        NITFC_OP_NONE
    } nitfc_op_t;

    typedef enum logic [2:0] {
        NITFC_MODE_ASYNC,
        NITFC_MODE_DDR1,
        NITFC_MODE_NVDDR,
        NITFC_MODE_DDR2,
        NITFC_MODE_NVDDR2
    } nitfc_mode_t;

    typedef struct packed {
        nitfc_phase_t phase;
        logic         wr;
        logic [12:0]  cnt;
        logic [7:0]   beats;
        logic [2:0]   warm;
        logic         strobe;
        logic [4:0]   div;
        logic         iclk;
        logic         cap;
        logic         dreq;
    } nitfc_chan_t;

    typedef struct packed {
        logic [31:0]             attr;
        logic [31:0]             ctl;
        logic [31:0]             rdata;
        logic [3:0]              odt;
        logic [7:0][3:0][31:0]   tim;
        nitfc_chan_t [7:0]       ch;
    } nitfc_state_t;

endpackage : nitfc_pkg

// ===== nitfc_props.sv
// Assertion checker for the NAND interface timing block
`timescale 1ns/1ps
`include "nitfc_cfg.svh"
module nitfc_props #(
    parameter int NCH = 8
) (
    input wire logic                  clk_in,
    input wire logic                  rst_b_in,
    input wire logic [11:0]           addr_in,
    input wire logic [31:0]           wdata_in,
    input wire logic                  wr_in,
    input wire logic                  rd_in,
    input wire logic [31:0]           rdata_out,
    input wire logic [NCH-1:0]        ch_start_in,
    input wire nitfc_pkg::nitfc_op_t  ch_op_in [NCH],
    input wire logic [NCH-1:0]        ch_abort_in,
    input wire logic [NCH-1:0]        ch_busy_out,
    input wire logic [NCH-1:0]        ch_re_n_out,
    input wire logic [NCH-1:0]        ch_re_c_out,
    input wire logic [NCH-1:0]        ch_re_c_oe_out,
    input wire logic [NCH-1:0]        ch_dqs_out,
    input wire logic [NCH-1:0]        ch_dqs_c_out,
    input wire logic [NCH-1:0]        ch_dqs_oe_out,
    input wire logic [NCH-1:0]        ch_dqs_c_oe_out,
    input wire logic [NCH-1:0]        ch_iface_clk_out,
    input wire logic [3:0]            odt_sel_out
);
    import nitfc_pkg::*;
    logic [31:0] attr_ff;
    logic [4:0]  res_ff;
    logic [5:0]  half_ff;
    logic        seen_ff;
    logic        iclk_ff;
    // A period is only judged after a full half period under the current divider
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            attr_ff <= `NITFC_ATTR_RST;
            res_ff  <= 5'h00;
            half_ff <= 6'h00;
            seen_ff <= 1'b0;
            iclk_ff <= 1'b0;
        end else begin
            iclk_ff <= ch_iface_clk_out[0];
            half_ff <= (ch_iface_clk_out[0] != iclk_ff) ? 6'h01 : half_ff + 6'h01;
            if (wr_in && addr_in == `NITFC_ADDR_ATTR) begin
                attr_ff <= wdata_in & `NITFC_ATTR_MASK;
            end
            if (wr_in && addr_in == `NITFC_ADDR_PW) begin
                res_ff  <= wdata_in[4:0];
                seen_ff <= 1'b0;
            end else if (ch_iface_clk_out[0] != iclk_ff) begin
                seen_ff <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_take;
        ch_start_in[0] && !ch_busy_out[0] && !ch_abort_in[0] && ch_op_in[0] != NITFC_OP_NONE;
    endsequence
    sequence s_abort;
        ch_abort_in[0] && ch_busy_out[0];
    endsequence
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside a read answer");
    a_attr_read: assert property (rd_in && addr_in == `NITFC_ADDR_ATTR
        |=> rdata_out == attr_ff)
        else $error("attribute read does not return written field");
    a_dqsc_gate: assert property (ch_dqs_c_oe_out == (ch_dqs_oe_out & {NCH{attr_ff[13]}}))
        else $error("complement strobe enable wrong");
    a_rec_gate: assert property (|ch_re_c_oe_out |-> attr_ff[12])
        else $error("complement read enable driven while disabled");
    a_odt_range: assert property (odt_sel_out <= `NITFC_ODT_MAX)
        else $error("termination code reserved value driven");
    a_abort_quiet: assert property (s_abort |=> ch_re_n_out[0] && !ch_dqs_oe_out[0])
        else $error("strobes active after abort");
    a_start_busy: assert property (s_take |=> ch_busy_out[0])
        else $error("channel not busy after start");
    a_iclk_period: assert property (seen_ff && ch_iface_clk_out[0] != iclk_ff
        |-> half_ff == {1'b0, res_ff} + 6'h01)
        else $error("interface clock half period wrong");
    a_rec_compl: assert property (((ch_re_c_out ^ ch_re_n_out) | ~ch_re_c_oe_out) == '1)
        else $error("complement read enable not inverse of read enable");
    a_dqsc_compl: assert property (((ch_dqs_c_out ^ ch_dqs_out) | ~ch_dqs_c_oe_out) == '1)
        else $error("complement strobe not inverse of strobe");
endmodule : nitfc_props

bind nitfc_top nitfc_props #(.NCH(NCH)) u_props (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ch_start_in(ch_start_in),
    .ch_op_in(ch_op_in), .ch_abort_in(ch_abort_in), .ch_busy_out(ch_busy_out),
    .ch_re_n_out(ch_re_n_out), .ch_re_c_out(ch_re_c_out), .ch_re_c_oe_out(ch_re_c_oe_out),
    .ch_dqs_out(ch_dqs_out), .ch_dqs_c_out(ch_dqs_c_out),
    .ch_dqs_oe_out(ch_dqs_oe_out), .ch_dqs_c_oe_out(ch_dqs_c_oe_out),
    .ch_iface_clk_out(ch_iface_clk_out), .odt_sel_out(odt_sel_out));

// ===== nitfc_flash_model.sv
// Ready/busy model of the flash devices on each channel
`timescale 1ns/1ps
module nitfc_flash_model #(
    parameter int NCH      = 8,
    parameter int BUSY_CYC = 10
) (
    input  wire logic           clk_in,
    input  wire logic           rst_b_in,
    input  wire logic [NCH-1:0] prog_in,
    output logic      [NCH-1:0] rb_out
);
    logic [NCH-1:0][7:0] cnt_ff;
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < NCH; i++) begin
            if (!rst_b_in) begin
                cnt_ff[i] <= 8'h00;
            end else if (prog_in[i]) begin
                cnt_ff[i] <= 8'(BUSY_CYC);
            end else if (cnt_ff[i] != 8'h00) begin
                cnt_ff[i] <= cnt_ff[i] - 8'h01;
            end
        end
    end
    // Ready only once the array operation has run its course
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rb_out[i] = (cnt_ff[i] == 8'h00);
        end
    end
endmodule : nitfc_flash_model

// ===== tb_nitfc_top.sv
// Testbench for the NAND interface timing block
`timescale 1ns/1ps
`include "nitfc_cfg.svh"
module tb_nitfc_top;
    import nitfc_pkg::*;
    logic            clk_in   = 1'b0;
    logic            rst_b_in = 1'b0;
    logic [11:0]     addr     = 12'h000;
    logic [31:0]     wdata    = 32'h0;
    logic            wr       = 1'b0;
    logic            rd       = 1'b0;
    logic [7:0]      start    = 8'h00;
    logic [7:0]      abort    = 8'h00;
    logic [7:0]      prog     = 8'h00;
    logic [7:0][7:0] len      = '0;
    nitfc_op_t       op [8];
    logic [31:0]     rdata;
    logic [3:0]      odt;
    logic [7:0]      rb, busy, rec_oe, dqsc_oe, cap, dreq;
    int              n_fail = 0;
    int              cmp_count = 0;
    int              n, ncap, nreq, nrc;
    logic [11:0]     base [4] = '{`NITFC_ADDR_PW, `NITFC_ADDR_LB, `NITFC_ADDR_TG, `NITFC_ADDR_SA};
    logic [31:0]     mask [4] = '{`NITFC_PW_MASK, `NITFC_LB_MASK, `NITFC_TG_MASK, `NITFC_SA_MASK};
    int              wcnt [5] = '{0, 1, 2, 4, 0};

    nitfc_top DUT (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ch_start_in(start),
        .ch_op_in(op), .ch_len_in(len), .ch_abort_in(abort), .ch_rb_in(rb),
        .ch_busy_out(busy), .ch_re_n_out(), .ch_re_c_out(), .ch_re_c_oe_out(rec_oe),
        .ch_dqs_out(), .ch_dqs_oe_out(), .ch_dqs_c_out(), .ch_dqs_c_oe_out(dqsc_oe),
        .ch_iface_clk_out(), .ch_capture_out(cap), .ch_data_req_out(dreq), .odt_sel_out(odt));
    nitfc_flash_model u_flash (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .prog_in(prog), .rb_out(rb));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1 check(rdata, exp);
    endtask : reg_rd

    // Counts busy cycles on channel 0; abort is raised once ab busy cycles were seen
    task automatic run(input nitfc_op_t o, input int ab, input logic bsy);
        @(posedge clk_in);
        op[0]    <= o;
        len[0]   <= 8'h03;
        start[0] <= 1'b1;
        prog[0]  <= bsy;
        @(posedge clk_in);
        start[0] <= 1'b0;
        prog[0]  <= 1'b0;
        n = 0;
        ncap = 0;
        nreq = 0;
        nrc = 0;
        forever begin
            #1;
            if (busy[0] !== 1'b1 || n > 600) break;
            n++;
            ncap += int'(cap[0]);
            nreq += int'(dreq[0]);
            nrc += int'(rec_oe[0] | dqsc_oe[0]);
            @(posedge clk_in);
            abort[0] <= (n == ab);
        end
        $display("op %0d done after %0d cycles", o, n);
    endtask : run

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        n_fail++;
        test_done();
    end

    initial begin
        for (int i = 0; i < 8; i++) op[i] = NITFC_OP_NONE;
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        reg_rd(`NITFC_ADDR_ATTR, `NITFC_ATTR_RST);
        reg_rd(12'h1fc, 32'h0);
        for (int c = 0; c < 8; c++) begin
            for (int r = 0; r < 4; r++) begin
                reg_wr(base[r] + 12'(8 * c), ~32'(c));
            end
        end
        for (int c = 0; c < 8; c++) begin
            for (int r = 0; r < 4; r++) begin
                reg_rd(base[r] + 12'(8 * c), ~32'(c) & mask[r]);
            end
        end
        $display("register map test done");
        reg_wr(`NITFC_ADDR_PW, 32'h0002_0001);
        reg_wr(`NITFC_ADDR_LB, 32'h0000_0101);
        reg_wr(`NITFC_ADDR_TG, 32'h0302_0405);
        reg_wr(`NITFC_ADDR_SA, 32'h2101_0000);
        for (int v = 0; v < 16; v++) begin
            reg_wr(`NITFC_ADDR_ATTR, 32'(v) << 8);
            repeat (2) @(posedge clk_in);
            #1 check(32'(odt), (v <= 5) ? 32'(v) : 32'h0);
        end
        reg_wr(`NITFC_ADDR_CTL, 32'h0000_2100);
        repeat (2) @(posedge clk_in);
        #1 check(32'(odt), 32'h2);
        reg_rd(`NITFC_ADDR_ATTR, 32'h0000_0f00);
        reg_wr(`NITFC_ADDR_CTL, 32'h0);
        $display("termination test done");
        for (int w = 0; w < 5; w++) begin
            reg_wr(`NITFC_ADDR_ATTR, (w[0] ? 32'h3000 : 32'h0) | 32'(w * 17));
            run(NITFC_OP_READ, 0, 1'b0);
            check(n, 15 + 2 * (wcnt[w] + 3));
            check(ncap, 3);
            check(nrc != 0, w[0]);
            run(NITFC_OP_WRITE, 0, 1'b0);
            check(n, 13 + 3 * (wcnt[w] + 3));
            check(nreq, 3);
            check(nrc != 0, w[0]);
        end
        run(NITFC_OP_TURN, 0, 1'b0);
        check(n, 4);
        run(NITFC_OP_READ, 4, 1'b0);
        check(n, 11);
        run(NITFC_OP_READ, 0, 1'b1);
        check(n, 31);
        reg_wr(`NITFC_ADDR_CTL, 32'h3);
        run(NITFC_OP_READ, 0, 1'b0);
        check(n, 23);
        reg_wr(`NITFC_ADDR_CTL, 32'h2);
        run(NITFC_OP_READ, 0, 1'b0);
        check(ncap, 3);
        // Ten amble and beat ticks of four cycles each, plus gap and tail, plus divider phase
        check(n >= 45 && n <= 48, 1'b1);
        reg_wr(`NITFC_ADDR_PW, 32'h0002_0003);
        repeat (50) @(posedge clk_in);
        reg_wr(`NITFC_ADDR_CTL, 32'h0);
        $display("channel sequencer test done");
        test_done();
    end
endmodule : tb_nitfc_top
